// File: design/sdcs_pkg.sv
// sdcs_pkg: constants, types and cycle arithmetic for the command-spacing checker
package sdcs_pkg;

    // clock rate of mclk, in picoseconds per cycle
    localparam int CLK_PERIOD_PS = 50000;

    // width of every spacing counter
    localparam int GAP_W = 8;
    localparam int NUM_BANKS = 8;

    // round a picosecond minimum up to whole cycles, never below one
    function automatic int sdcs_ps_to_cyc(input int ps);
        int cyc;
        cyc = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (cyc < 1) ? 1 : cyc;
    endfunction

    // larger of a clock-count term and a picosecond term
    function automatic int sdcs_mix_cyc(input int nck, input int ps);
        int t;
        t = sdcs_ps_to_cyc(ps);
        return (nck > t) ? nck : t;
    endfunction

    // timing figures as printed, in their own units
    localparam int TMRD_NCK = 4;
    localparam int TMOD_NCK = 12;
    localparam int TMOD_PS = 15000;
    localparam int TCCD_NCK = 4;
    localparam int TRTP_NCK = 4;
    localparam int TRTP_PS = 7500;
    localparam int TWTR_NCK = 4;
    localparam int TWTR_PS = 7500;
    localparam int TMPRR_NCK = 1;
    localparam int TRRD_NCK = 4;
    localparam int TRRD_10_PS = 10000;
    localparam int TRRD_7P5_PS = 7500;
    localparam int TRRD_6_PS = 6000;
    // precharge period, a plain default since no figure is fixed here
    localparam int TRP_PS = 15000;
    // write latency, read latency and burst length, plain defaults
    localparam int WR_LATENCY = 5;
    localparam int RD_LATENCY = 6;
    localparam int BURST_LEN = 8;
    localparam int RD_SPAN = RD_LATENCY + BURST_LEN / 2;

    // derived cycle counts
    localparam logic [GAP_W-1:0] TMRD_CYC = GAP_W'(TMRD_NCK);
    localparam logic [GAP_W-1:0] TMOD_CYC = GAP_W'(sdcs_mix_cyc(TMOD_NCK, TMOD_PS));
    localparam logic [GAP_W-1:0] TCCD_CYC = GAP_W'(TCCD_NCK);
    localparam logic [GAP_W-1:0] TRTP_CYC = GAP_W'(sdcs_mix_cyc(TRTP_NCK, TRTP_PS));
    localparam logic [GAP_W-1:0] TMPRR_CYC = GAP_W'(TMPRR_NCK);
    localparam logic [GAP_W-1:0] TRRD_10_CYC = GAP_W'(sdcs_mix_cyc(TRRD_NCK, TRRD_10_PS));
    localparam logic [GAP_W-1:0] TRRD_7P5_CYC = GAP_W'(sdcs_mix_cyc(TRRD_NCK, TRRD_7P5_PS));
    localparam logic [GAP_W-1:0] TRRD_6_CYC = GAP_W'(sdcs_mix_cyc(TRRD_NCK, TRRD_6_PS));
    localparam logic [GAP_W-1:0] TRP_CYC = GAP_W'(sdcs_ps_to_cyc(TRP_PS));
    // internal write starts after write latency plus the burst
    localparam logic [GAP_W-1:0] WR_BURST_CYC = GAP_W'(WR_LATENCY + BURST_LEN / 2);
    localparam logic [GAP_W-1:0] TWTR_LOAD =
        GAP_W'(WR_LATENCY + BURST_LEN / 2 + sdcs_mix_cyc(TWTR_NCK, TWTR_PS));

    // speed bin codes
    localparam logic [1:0] BIN_800 = 2'h0;
    localparam logic [1:0] BIN_1066 = 2'h1;

    // command codes on the command pins
    typedef enum logic [2:0] {
        SDCS_OP_NOP,
        SDCS_OP_MRS,
        SDCS_OP_MPR_EXIT,
        SDCS_OP_ACT,
        SDCS_OP_RD,
        SDCS_OP_WR,
        SDCS_OP_WRA,
        SDCS_OP_PRE
    } sdcs_op_type;

    // one command slot
    typedef struct packed {
        logic valid;
        sdcs_op_type op;
        logic [2:0] bank;
    } sdcs_cmd_type;

    // static configuration
    typedef struct packed {
        logic [1:0] speed_bin;
        logic page_2kb;
        logic [4:0] wr_recovery;
    } sdcs_cfg_type;

    // one-cycle violation flags
    typedef struct packed {
        logic mrd;
        logic mod;
        logic ccd;
        logic rtp;
        logic wtr;
        logic rrd;
        logic dal;
        logic mprr;
        logic wpre;
        logic wpst;
    } sdcs_viol_type;

    localparam sdcs_cmd_type CMD_IDLE = '0;
    localparam sdcs_cfg_type CFG_RESET = '0;
    localparam sdcs_viol_type VIOL_NONE = '0;

endpackage

// File: design/sdcs_gap_timer.sv
// sdcs_gap_timer: down-counter that holds busy for one less than the loaded number of cycles
`timescale 1ns/100ps
module sdcs_gap_timer (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [sdcs_pkg::GAP_W-1:0] load_val,
    output logic busy
);
    import sdcs_pkg::*;

    logic [GAP_W-1:0] count; // cycles left before the next command is legal

    // a load of n keeps busy for the n-1 cycles after the loading edge,
    // so a command exactly n cycles later is legal and is not flagged
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            count <= '0;
        end else if (load) begin
            count <= load_val - GAP_W'(1);
        end else if (count != '0) begin
            count <= count - GAP_W'(1);
        end
    end

    assign busy = (count != '0);

endmodule

// File: design/sdcs_core.sv
// sdcs_core: command-spacing checker and read-strobe framer of the memory
`timescale 1ns/100ps
// Function
// - auto-precharge recovery is WR plus ceil(tRP/tCK)
// - read strobe preamble before read data
// - read strobe has no postamble cycle after the last edge
// - read strobe driven from RL-1
// - read strobe released at RL+BL/2
module sdcs_core (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire sdcs_pkg::sdcs_cmd_type cmd_pin,
    input wire sdcs_pkg::sdcs_cfg_type cfg_pin,
    input wire logic strobe_i,
    input wire logic wr_strobe_oe_i,
    output logic strobe_o,
    output logic strobe_oe,
    output logic rd_data_valid,
    output sdcs_pkg::sdcs_viol_type viol
);
    import sdcs_pkg::*;

    sdcs_cmd_type cmd_m; // first synchroniser stage, read only by cmd_q
    sdcs_cmd_type cmd_q; // command as seen by the checker
    sdcs_cfg_type cfg_m; // first stage of the static settings
    sdcs_cfg_type cfg_q; // settings as used by the counters
    logic [1:0] wstb_m; // first stage of strobe level and controller enable
    logic [1:0] wstb_q; // synchronised strobe level and enable
    logic [1:0] wstb_p1; // one cycle older
    logic wstb_p2_lvl; // strobe level two cycles older

    // pins arrive from the controller's domain, two flops before any use
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_m <= CMD_IDLE;
            cmd_q <= CMD_IDLE;
        end else begin
            cmd_m <= cmd_pin;
            cmd_q <= cmd_m;
        end
    end

    // settings are static but still crossed, so a late change cannot glitch the loads
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_m <= CFG_RESET;
            cfg_q <= CFG_RESET;
        end else begin
            cfg_m <= cfg_pin;
            cfg_q <= cfg_m;
        end
    end

    // write strobe sampling with a short history for edge checks
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wstb_m <= 2'h0;
            wstb_q <= 2'h0;
            wstb_p1 <= 2'h0;
            wstb_p2_lvl <= 1'b0;
        end else begin
            wstb_m <= {wr_strobe_oe_i, strobe_i};
            wstb_q <= wstb_m;
            wstb_p1 <= wstb_q;
            wstb_p2_lvl <= wstb_p1[0];
        end
    end

    // command decode
    logic is_mrs; // mode set or leaving MPR, both touch the mode registers
    logic is_mpr_exit;
    logic is_act;
    logic is_rd;
    logic is_wr; // plain write or write with auto-precharge
    logic is_wra;
    logic is_pre;
    logic is_any; // any command other than a no-op

    always_comb begin
        is_any = cmd_q.valid && (cmd_q.op != SDCS_OP_NOP);
        is_mpr_exit = cmd_q.valid && (cmd_q.op == SDCS_OP_MPR_EXIT);
        is_mrs = cmd_q.valid && ((cmd_q.op == SDCS_OP_MRS) || is_mpr_exit);
        is_act = cmd_q.valid && (cmd_q.op == SDCS_OP_ACT);
        is_rd = cmd_q.valid && (cmd_q.op == SDCS_OP_RD);
        is_wra = cmd_q.valid && (cmd_q.op == SDCS_OP_WRA);
        is_wr = is_wra || (cmd_q.valid && (cmd_q.op == SDCS_OP_WR));
        is_pre = cmd_q.valid && (cmd_q.op == SDCS_OP_PRE);
    end

    // activate spacing picked from speed bin and page size
    logic [GAP_W-1:0] rrd_cyc;

    always_comb begin
        rrd_cyc = TRRD_6_CYC;
        case (cfg_q.speed_bin)
            BIN_800: begin
                rrd_cyc = TRRD_10_CYC;
            end
            BIN_1066: begin
                rrd_cyc = cfg_q.page_2kb ? TRRD_10_CYC : TRRD_7P5_CYC;
            end
            default: begin
                rrd_cyc = cfg_q.page_2kb ? TRRD_7P5_CYC : TRRD_6_CYC;
            end
        endcase
    end

    // recovery plus precharge, counted from the end of the write burst
    logic [GAP_W-1:0] dal_cyc;
    logic [GAP_W-1:0] dal_load;

    always_comb begin
        dal_cyc = {3'h0, cfg_q.wr_recovery} + TRP_CYC;
        dal_load = dal_cyc + WR_BURST_CYC;
    end

    // shared spacing counters; mod, wtr and rrd are loaded with max() figures, the rest with plain clock counts
    logic mrd_busy;
    logic mod_busy;
    logic ccd_busy;
    logic wtr_busy;
    logic rrd_busy;
    logic mprr_busy;

    sdcs_gap_timer u_mrd (.mclk(mclk), .sys_rst(sys_rst), .load(is_mrs),
        .load_val(TMRD_CYC), .busy(mrd_busy));
    sdcs_gap_timer u_mod (.mclk(mclk), .sys_rst(sys_rst), .load(is_mrs),
        .load_val(TMOD_CYC), .busy(mod_busy));
    sdcs_gap_timer u_ccd (.mclk(mclk), .sys_rst(sys_rst), .load(is_rd || is_wr),
        .load_val(TCCD_CYC), .busy(ccd_busy));
    sdcs_gap_timer u_wtr (.mclk(mclk), .sys_rst(sys_rst), .load(is_wr),
        .load_val(TWTR_LOAD), .busy(wtr_busy));
    sdcs_gap_timer u_rrd (.mclk(mclk), .sys_rst(sys_rst), .load(is_act),
        .load_val(rrd_cyc), .busy(rrd_busy));
    sdcs_gap_timer u_mprr (.mclk(mclk), .sys_rst(sys_rst), .load(is_mpr_exit),
        .load_val(TMPRR_CYC), .busy(mprr_busy));

    // per-bank counters for read-to-precharge and auto-precharge recovery
    logic [NUM_BANKS-1:0] rtp_busy;
    logic [NUM_BANKS-1:0] dal_busy;

    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        sdcs_gap_timer u_rtp (.mclk(mclk), .sys_rst(sys_rst),
            .load(is_rd && (cmd_q.bank == 3'(b))),
            .load_val(TRTP_CYC), .busy(rtp_busy[b]));
        sdcs_gap_timer u_dal (.mclk(mclk), .sys_rst(sys_rst),
            .load(is_wra && (cmd_q.bank == 3'(b))),
            .load_val(dal_load), .busy(dal_busy[b]));
    end

    // last activated bank; same-bank activates fall under a different limit
    logic [2:0] last_act_bank;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            last_act_bank <= 3'h0;
        end else if (is_act) begin
            last_act_bank <= cmd_q.bank;
        end
    end

    // spacing and strobe framing checks, one flag per limit
    sdcs_viol_type next_viol;

    always_comb begin
        next_viol = VIOL_NONE;
        next_viol.mrd = is_mrs && mrd_busy;
        next_viol.mod = is_any && !is_mrs && mod_busy;
        next_viol.ccd = (is_rd || is_wr) && ccd_busy;
        next_viol.rtp = is_pre && rtp_busy[cmd_q.bank];
        next_viol.wtr = is_rd && wtr_busy;
        // only different banks are policed here
        next_viol.rrd = is_act && rrd_busy && (cmd_q.bank != last_act_bank);
        next_viol.dal = is_act && dal_busy[cmd_q.bank];
        next_viol.mprr = is_any && mprr_busy;
        // enable rises with the strobe already high: no low preamble cycle
        next_viol.wpre = wstb_q[1] && !wstb_p1[1] && wstb_q[0];
        // enable drops right after a strobe edge: no postamble cycle
        next_viol.wpst = !wstb_q[1] && wstb_p1[1] && (wstb_p1[0] != wstb_p2_lvl);
    end

    // flags are one-cycle pulses, registered so the outputs come from flops
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            viol <= VIOL_NONE;
        end else begin
            viol <= next_viol;
        end
    end

    // read history: bit i set means a read stands i+1 cycles before the output
    logic [RD_SPAN-1:0] rd_hist;
    logic [RD_SPAN-1:0] next_rd_hist;

    always_comb begin
        next_rd_hist = {rd_hist[RD_SPAN-2:0], is_rd};
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_hist <= '0;
        end else begin
            rd_hist <= next_rd_hist;
        end
    end

    // strobe framing; overlapping reads at column spacing merge seamlessly
    logic next_strobe_o;
    logic next_strobe_oe;
    logic next_rd_valid;

    always_comb begin
        next_strobe_o = 1'b0;
        next_strobe_oe = 1'b0;
        next_rd_valid = 1'b0;
        for (int i = 0; i < RD_SPAN; i++) begin
            if (next_rd_hist[i]) begin
                // drive from RL-1 (preamble, low) to the cycle before RL+BL/2
                if ((i + 1 >= RD_LATENCY - 1) && (i + 1 < RD_SPAN)) begin
                    next_strobe_oe = 1'b1;
                end
                // data cycles toggle high then low, so the last cycle ends low
                if ((i + 1 >= RD_LATENCY) && (i + 1 < RD_SPAN)) begin
                    next_rd_valid = 1'b1;
                    if (((i + 1 - RD_LATENCY) % 2) == 0) begin
                        next_strobe_o = 1'b1;
                    end
                end
            end
        end
    end

    // strobe pin outputs straight from flops
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            strobe_o <= 1'b0;
            strobe_oe <= 1'b0;
            rd_data_valid <= 1'b0;
        end else begin
            strobe_o <= next_strobe_o;
            strobe_oe <= next_strobe_oe;
            rd_data_valid <= next_rd_valid;
        end
    end

endmodule

// File: tb/sdcs_core_monitor.sv
// sdcs_core_monitor: timing checks at the ports of the spacing checker
`timescale 1ns/100ps
module sdcs_core_monitor (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire sdcs_pkg::sdcs_cmd_type cmd_pin,
    input wire logic strobe_i,
    input wire logic wr_strobe_oe_i,
    input wire logic strobe_o,
    input wire logic strobe_oe,
    input wire logic rd_data_valid,
    input wire sdcs_pkg::sdcs_viol_type viol
);
    import sdcs_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // cycles since the last command of each class, saturating at 31
    logic [4:0] a_md, a_col, a_wr, a_rd, a_act;
    logic [2:0] last_bank; // bank of the latest activate
    logic md, oth, col, wr, rd, act, nb; // command classes at the pins
    assign md = cmd_pin.valid && cmd_pin.op inside {SDCS_OP_MRS, SDCS_OP_MPR_EXIT};
    assign oth = cmd_pin.valid && cmd_pin.op != SDCS_OP_NOP && !md;
    assign col = cmd_pin.valid && cmd_pin.op inside {SDCS_OP_RD, SDCS_OP_WR, SDCS_OP_WRA};
    assign wr = cmd_pin.valid && cmd_pin.op inside {SDCS_OP_WR, SDCS_OP_WRA};
    assign rd = cmd_pin.valid && cmd_pin.op == SDCS_OP_RD;
    assign act = cmd_pin.valid && cmd_pin.op == SDCS_OP_ACT;
    assign nb = cmd_pin.bank != last_bank;
    function automatic logic [4:0] age(input logic e, input logic [4:0] a);
        return e ? 5'h01 : (a == 5'h1f) ? a : a + 5'h01;
    endfunction
    // reset saturates the ages, so a first command never counts as too close
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            {a_md, a_col, a_wr, a_rd, a_act} <= '1;
            last_bank <= 3'h0;
        end else begin
            a_md <= age(md, a_md);
            a_col <= age(col, a_col);
            a_wr <= age(wr, a_wr);
            a_rd <= age(rd, a_rd);
            a_act <= age(act, a_act);
            last_bank <= act ? cmd_pin.bank : last_bank;
        end
    end
    // read strobe frame pieces
    sequence pre_s;
        strobe_oe && !strobe_o && !rd_data_valid;
    endsequence
    sequence beat_s(logic b);
        rd_data_valid && strobe_oe && strobe_o == b;
    endsequence
    sequence burst_s;
        beat_s(1'b1) ##1 beat_s(1'b0) ##1 beat_s(1'b1) ##1 beat_s(1'b0);
    endsequence
    mrd_gap_a: assert property (md |-> ##3 viol.mrd == ($past(a_md, 3) < 5'h04))
        else $error("mode set spacing flag wrong");
    mod_gap_a: assert property (oth |-> ##3 viol.mod == ($past(a_md, 3) < 5'h0c))
        else $error("mode update delay flag wrong");
    ccd_gap_a: assert property (col |-> ##3 viol.ccd == ($past(a_col, 3) < 5'h04))
        else $error("column spacing flag wrong");
    wtr_gap_a: assert property (rd |-> ##3 viol.wtr == ($past(a_wr, 3) < 5'h0d))
        else $error("write to read flag wrong");
    rrd_gap_a: assert property (act |-> ##3 viol.rrd == ($past(a_act, 3) < 5'h04 && $past(nb, 3)))
        else $error("activate spacing flag wrong");
    rd_pre_a: assert property (rd && a_rd > 5'h04 |-> ##7 pre_s)
        else $error("read preamble missing");
    // a follower closer than column spacing breaks the rules, so its overlap is not judged
    rd_burst_a: assert property (rd && a_rd >= 5'h04 ##1 (!rd) [*3] |-> ##5 burst_s)
        else $error("read burst framing wrong");
    rd_release_a: assert property ($fell(strobe_oe) |-> $past(rd, 12))
        else $error("read strobe released at wrong time");
    wpre_flag_a: assert property ($rose(wr_strobe_oe_i) && strobe_i |-> ##[2:5] viol.wpre)
        else $error("bad write preamble not flagged");
    wpst_flag_a: assert property ($fell(wr_strobe_oe_i) && $past(strobe_i) != $past(strobe_i, 2)
        |-> ##[2:5] viol.wpst)
        else $error("bad write postamble not flagged");
endmodule

// File: tb/sdcs_ctrl_model.sv
// sdcs_ctrl_model: controller side write strobe and the shared strobe wire
`timescale 1ns/100ps
module sdcs_ctrl_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire sdcs_pkg::sdcs_cmd_type cmd_pin,
    input wire logic bad_pre,
    input wire logic bad_pst,
    input wire logic strobe_o,
    input wire logic strobe_oe,
    output logic strobe_i,
    output logic wr_strobe_oe_i
);
    import sdcs_pkg::*;
    logic [3:0] ph; // phase since a write command, 0 when idle
    logic [3:0] idx; // position in the driven frame
    logic lvl; // level this side drives
    logic tgl; // a floating wire wanders, never holds the last value
    // a write restarts the frame; the bench spaces writes so frames never overlap
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ph <= 4'h0;
            tgl <= 1'b0;
        end else begin
            tgl <= !tgl;
            if (cmd_pin.valid && cmd_pin.op inside {SDCS_OP_WR, SDCS_OP_WRA}) begin
                ph <= 4'h1;
            end else if (ph == 4'(WR_LATENCY + 5)) begin
                ph <= 4'h0;
            end else if (ph != 4'h0) begin
                ph <= ph + 4'h1;
            end
        end
    end
    assign wr_strobe_oe_i = ph >= 4'(WR_LATENCY);
    assign idx = ph - 4'(WR_LATENCY);
    // low preamble, four beats, postamble held low unless told to break it
    assign lvl = (idx == 4'h0) ? bad_pre : (idx == 4'h5) ? bad_pst : idx[0];
    assign strobe_i = wr_strobe_oe_i ? lvl : strobe_oe ? strobe_o : tgl;
endmodule

// File: tb/sdcs_core_tb_top.sv
// sdcs_core_tb_top: self-checking bench for the command-spacing checker
`timescale 1ns/100ps
module sdcs_core_tb_top;
    import sdcs_pkg::*;
    logic mclk, sys_rst, bad_pre, bad_pst, strobe_i, wr_strobe_oe_i;
    logic strobe_o, strobe_oe, rd_data_valid;
    sdcs_cmd_type cmd;
    sdcs_cfg_type cfg;
    sdcs_viol_type viol, acc, xv; // seen flags, sticky flags, forced extras
    int error_cnt = 0, cmp_count = 0, beats;
    sdcs_op_type ta[7] = '{SDCS_OP_MRS, SDCS_OP_MPR_EXIT, SDCS_OP_RD, SDCS_OP_RD,
        SDCS_OP_WR, SDCS_OP_ACT, SDCS_OP_WRA};
    sdcs_op_type tz[7] = '{SDCS_OP_MRS, SDCS_OP_ACT, SDCS_OP_WR, SDCS_OP_PRE,
        SDCS_OP_RD, SDCS_OP_ACT, SDCS_OP_ACT};
    sdcs_core i_dut (.mclk(mclk), .sys_rst(sys_rst), .cmd_pin(cmd), .cfg_pin(cfg),
        .strobe_i(strobe_i), .wr_strobe_oe_i(wr_strobe_oe_i), .strobe_o(strobe_o),
        .strobe_oe(strobe_oe), .rd_data_valid(rd_data_valid), .viol(viol));
    sdcs_ctrl_model i_ctrl (.mclk(mclk), .sys_rst(sys_rst), .cmd_pin(cmd), .bad_pre(bad_pre),
        .bad_pst(bad_pst), .strobe_o(strobe_o), .strobe_oe(strobe_oe), .strobe_i(strobe_i),
        .wr_strobe_oe_i(wr_strobe_oe_i));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    function automatic logic col_op(sdcs_op_type o);
        return o >= SDCS_OP_RD && o <= SDCS_OP_WRA;
    endfunction
    // flags due when command b follows command a after g cycles
    function automatic sdcs_viol_type exp_viol(sdcs_op_type a, sdcs_op_type b, logic same,
        logic [4:0] wrr, int g);
        sdcs_viol_type e;
        logic ma, mb;
        e = VIOL_NONE;
        ma = a == SDCS_OP_MRS || a == SDCS_OP_MPR_EXIT;
        mb = b == SDCS_OP_MRS || b == SDCS_OP_MPR_EXIT;
        e.mrd = ma && mb && g < TMRD_NCK;
        e.mod = ma && !mb && g < TMOD_NCK;
        e.ccd = col_op(a) && col_op(b) && g < TCCD_NCK;
        e.rtp = a == SDCS_OP_RD && b == SDCS_OP_PRE && same && g < 4;
        e.wtr = col_op(a) && a != SDCS_OP_RD && b == SDCS_OP_RD && g < 13;
        e.rrd = a == SDCS_OP_ACT && b == SDCS_OP_ACT && !same && g < 4;
        e.dal = a == SDCS_OP_WRA && b == SDCS_OP_ACT && same
            && g < WR_LATENCY + BURST_LEN / 2 + wrr + 1;
        return e;
    endfunction
    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one clock, gathering flags and read beats as they go by
    task automatic tick();
        @(posedge mclk);
        acc = acc | viol;
        beats += rd_data_valid;
    endtask
    task automatic issue(sdcs_op_type op, logic [2:0] bk, int n);
        cmd <= '{1'b1, op, bk};
        tick();
        repeat (n - 1) begin
            cmd <= CMD_IDLE;
            tick();
        end
    endtask
    // two commands g cycles apart, then a quiet spell long enough for every limit
    task automatic pair(sdcs_op_type a, logic [2:0] ba, sdcs_op_type b, logic [2:0] bb, int g);
        sdcs_viol_type e;
        int nexp;
        e = exp_viol(a, b, ba == bb, cfg.wr_recovery, g) | xv;
        // reads closer than column spacing merge into one longer burst
        nexp = (a != SDCS_OP_RD) ? 0 : (b == SDCS_OP_RD && g < TCCD_NCK) ? g : 4;
        nexp += (b == SDCS_OP_RD) ? 4 : 0;
        acc = VIOL_NONE;
        beats = 0;
        issue(a, ba, g);
        issue(b, bb, 2);
        repeat (30) tick();
        chk(16'(acc), 16'(e));
        chk(16'(beats), 16'(nexp));
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        sdcs_op_type a, b;
        logic [2:0] ba, bb;
        int g;
        sys_rst = 1'b1;
        cmd = CMD_IDLE;
        cfg = '{2'h0, 1'b0, 5'h03};
        bad_pre = 1'b0;
        bad_pst = 1'b0;
        xv = VIOL_NONE;
        void'($urandom(32'h31137863));
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) tick();
        // every gap across each boundary
        for (int i = 0; i < 7; i++) begin
            for (int k = 1; k < 19; k++) begin
                pair(ta[i], 3'h2, tz[i], (i == 5) ? 3'h5 : 3'h2, k);
            end
        end
        $display("test gap sweep done");
        repeat (40) begin
            cfg <= '{2'($urandom_range(0, 3)), 1'($urandom_range(0, 1)), 5'($urandom_range(1, 7))};
            repeat (3) tick();
            a = sdcs_op_type'($urandom_range(1, 7));
            b = sdcs_op_type'($urandom_range(1, 7));
            ba = 3'($urandom);
            bb = $urandom_range(0, 1) ? ba : 3'($urandom);
            g = $urandom_range(1, 18);
            // column pairs get 10 more cycles, except a read followed by a write, whose strobe frames may overlap
            if (col_op(a) && col_op(b) && !(a == SDCS_OP_RD && b != SDCS_OP_RD)) g += 10;
            pair(a, ba, b, bb, g);
        end
        $display("test random pairs done");
        bad_pre <= 1'b1;
        xv.wpre = 1'b1;
        pair(SDCS_OP_WR, 3'h0, SDCS_OP_PRE, 3'h0, 8);
        bad_pre <= 1'b0;
        bad_pst <= 1'b1;
        xv = VIOL_NONE;
        xv.wpst = 1'b1;
        pair(SDCS_OP_WRA, 3'h1, SDCS_OP_PRE, 3'h1, 8);
        bad_pst <= 1'b0;
        xv = VIOL_NONE;
        $display("test write strobe faults done");
        // reset just as the preamble of a read frame starts
        issue(SDCS_OP_RD, 3'h1, 7);
        sys_rst <= 1'b1;
        repeat (2) tick();
        sys_rst <= 1'b0;
        repeat (2) tick();
        chk(16'({strobe_oe, strobe_o, rd_data_valid, viol}), 16'h0000);
        pair(SDCS_OP_MRS, 3'h0, SDCS_OP_MRS, 3'h0, 3);
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule
bind sdcs_core sdcs_core_monitor i_mon (.mclk(mclk), .sys_rst(sys_rst), .cmd_pin(cmd_pin),
    .strobe_i(strobe_i), .wr_strobe_oe_i(wr_strobe_oe_i), .strobe_o(strobe_o),
    .strobe_oe(strobe_oe), .rd_data_valid(rd_data_valid), .viol(viol));
